// ==== verilog/rtc_pkg.sv ====
package rtc_pkg;

    // register offsets on the register port
    localparam logic [7:0] SEC_ADDR     = 8'h40;
    localparam logic [7:0] MIN_ADDR     = 8'h41;
    localparam logic [7:0] HOUR_ADDR    = 8'h42;
    localparam logic [7:0] WEEKDAY_ADDR = 8'h43;
    localparam logic [7:0] MDAY_ADDR    = 8'h44;
    localparam logic [7:0] MONTH_ADDR   = 8'h45;
    localparam logic [7:0] YEAR_ADDR    = 8'h46;
    // pointer value that refreshes the shadow copy
    localparam logic [7:0] SNAP_ADDR    = 8'h00;

    // field positions
    localparam int HOUR_TEN_BIT   = 4;
    localparam int AFTERNOON_BIT  = 5;
    localparam int FORMAT12_BIT   = 6;
    localparam int MONTH_TEN_BIT  = 4;
    localparam int CENTURY_BIT    = 7;

    // writable field masks; other bits read as zero
    localparam logic [7:0] SEC_MASK     = 8'h7F;
    localparam logic [7:0] MIN_MASK     = 8'h7F;
    localparam logic [7:0] HOUR_MASK    = 8'h7F;
    localparam logic [7:0] WEEKDAY_MASK = 8'h07;
    localparam logic [7:0] MDAY_MASK    = 8'h3F;
    localparam logic [7:0] MONTH_MASK   = 8'h9F;
    localparam logic [7:0] YEAR_MASK    = 8'hFF;

    // reset values
    localparam logic [7:0] SEC_RST     = 8'h00;
    localparam logic [7:0] MIN_RST     = 8'h00;
    localparam logic [7:0] HOUR_RST    = 8'h00;
    localparam logic [7:0] WEEKDAY_RST = 8'h00;
    localparam logic [7:0] MDAY_RST    = 8'h01;
    localparam logic [7:0] MONTH_RST   = 8'h01;
    localparam logic [7:0] YEAR_RST    = 8'h00;

    // counter limits in BCD
    localparam logic [7:0] SEC_LAST     = 8'h59;
    localparam logic [7:0] MIN_LAST     = 8'h59;
    localparam logic [7:0] HOUR24_LAST  = 8'h23;
    localparam logic [7:0] HOUR12_LAST  = 8'h12;
    localparam logic [7:0] HOUR12_TURN  = 8'h11;
    localparam logic [7:0] HOUR12_FIRST = 8'h01;
    localparam logic [2:0] WEEKDAY_LAST = 3'h7;
    localparam logic [2:0] WEEKDAY_FIRST = 3'h1;
    localparam logic [7:0] MONTH_LAST   = 8'h12;
    localparam logic [7:0] YEAR_LAST    = 8'h99;
    localparam logic [7:0] BCD_ONE      = 8'h01;
    localparam logic [7:0] BCD_ZERO     = 8'h00;

    // timing: clock rate and host completion window after a seconds write
    localparam int  CLK_HZ        = 20_000_000;
    localparam int  TICK_HZ       = 1;
    localparam int  SET_WINDOW_MS = 500;
    localparam longint TICK_CYCLES_L = CLK_HZ / TICK_HZ;
    localparam longint SET_WINDOW_CYCLES_L = (CLK_HZ / 1000) * SET_WINDOW_MS;

    // one register access on the local port
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // full calendar in register layout
    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] weekday;
        logic [7:0] mday;
        logic [7:0] month;
        logic [7:0] year;
    } cal_t;

endpackage

// ==== verilog/rtc_bcd_digit_pair.sv ====
`timescale 1ns/1ns
// bcd increment with wrap to a given first value
module rtc_bcd_digit_pair
    import rtc_pkg::*;
(
    // value in
    input  wire logic [7:0] value_in,
    input  wire logic [7:0] last_in,
    input  wire logic [7:0] first_in,
    // result
    output logic      [7:0] next_out,
    output logic            wrap_out
);
    always_comb begin
        wrap_out = (value_in == last_in);
        if (wrap_out) begin
            next_out = first_in;
        end else if (value_in[3:0] >= 4'h9) begin
            next_out = {value_in[7:4] + 4'h1, 4'h0};
        end else begin
            next_out = {value_in[7:4], value_in[3:0] + 4'h1};
        end
    end
endmodule

// ==== verilog/rtc_tick_gen.sv ====
`timescale 1ns/1ns
// sub-second count-up chain; restart clears it so the next tick is a full second away
module rtc_tick_gen
    import rtc_pkg::*;
#(
    parameter int TICK_CYCLES = int'(TICK_CYCLES_L)
)(
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // control
    input  wire logic restart_in,
    // one-cycle tick
    output logic      tick_out
);
    logic [31:0] count;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count    <= 32'h0;
            tick_out <= 1'b0;
        end else if (restart_in) begin
            count    <= 32'h0;
            tick_out <= 1'b0;
        end else if (count == 32'(TICK_CYCLES - 1)) begin
            count    <= 32'h0;
            tick_out <= 1'b1;
        end else begin
            count    <= count + 32'h1;
            tick_out <= 1'b0;
        end
    end
endmodule

// ==== verilog/rtc_timekeeping_counters.sv ====
`timescale 1ns/1ns
// Behaviour
// - seconds count 0..59, wrap to 0, carry into minutes
// - seconds in BCD: units bits 3:0, tens bits 6:4
// - minutes count 0..59, wrap to 0, carry into hours
// - minutes in BCD: units bits 3:0, tens bits 6:4
// - hours run 1..12 in twelve-hour format, 0..23 in twenty-four-hour
// - hours units in bits 3:0, low tens bit in bit 4
// - hours bit 5 is afternoon flag in 12h, high tens bit in 24h
// - hours bit 6 selects format, 1 twelve-hour, resets to 0
// - weekday in bits 2:0, values 1..7, resets to 0
// - date of month counts 1..31
// - date units bits 3:0, tens bits 5:4, resets to 01
// - month counts 1..12
// - month units bits 3:0, tens bit 4, resets to 01
// - century bit 7 of month toggles when year wraps 99 to 0
// - year 0..99 BCD, units 3:0, tens 7:4, resets to 00
// - each register accessed as a whole 8-bit word, read and write
// - seconds write restarts sub-second chain; rest written within 0.5 s
// - reads come from shadow copy refreshed when pointer is zero
// - month end handles short months and leap years
// - weekday advances at midnight, cycling through seven values
module rtc_timekeeping_counters
    import rtc_pkg::*;
#(
    parameter int TICK_CYCLES = int'(TICK_CYCLES_L),
    parameter int SET_WINDOW_CYCLES = int'(SET_WINDOW_CYCLES_L)
)(
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    // register port
    input  wire reg_req_t   req_in,
    output logic      [7:0] rdata_out,
    output logic            rvalid_out,
    // status
    output logic            tick_out,
    output logic            set_window_open_out
);
    cal_t        live;
    cal_t        shadow;
    logic        tick;
    logic [31:0] window_count;

    // one register per counter, so each has a single writing process
    logic [7:0]  seconds;
    logic [7:0]  minutes;
    logic [7:0]  hours;
    logic [7:0]  day_of_week;
    logic [7:0]  month_day;
    logic [7:0]  months;
    logic [7:0]  years;

    // write strobes, at most one high per request
    logic        sec_write;
    logic        min_write;
    logic        hour_write;
    logic        weekday_write;
    logic        mday_write;
    logic        month_write;
    logic        year_write;

    assign live = '{
        sec:     seconds,
        min:     minutes,
        hour:    hours,
        weekday: day_of_week,
        mday:    month_day,
        month:   months,
        year:    years
    };

    always_comb begin
        sec_write     = 1'b0;
        min_write     = 1'b0;
        hour_write    = 1'b0;
        weekday_write = 1'b0;
        mday_write    = 1'b0;
        month_write   = 1'b0;
        year_write    = 1'b0;
        if (req_in.wr) begin
            if (req_in.addr == SEC_ADDR) begin
                sec_write = 1'b1;
            end else if (req_in.addr == MIN_ADDR) begin
                min_write = 1'b1;
            end else if (req_in.addr == HOUR_ADDR) begin
                hour_write = 1'b1;
            end else if (req_in.addr == WEEKDAY_ADDR) begin
                weekday_write = 1'b1;
            end else if (req_in.addr == MDAY_ADDR) begin
                mday_write = 1'b1;
            end else if (req_in.addr == MONTH_ADDR) begin
                month_write = 1'b1;
            end else if (req_in.addr == YEAR_ADDR) begin
                year_write = 1'b1;
            end
        end
    end

    rtc_tick_gen #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk_in     (clk_in),
        .rst_in     (rst_in),
        .restart_in (sec_write),
        .tick_out   (tick)
    );

    // counter increment stages
    logic [7:0] next_sec, next_min, next_year, next_month, next_mday;
    logic       sec_wrap, min_wrap, year_wrap, month_wrap, mday_wrap;
    logic [7:0] next_hour;
    logic       hour_wrap;
    logic [2:0] next_weekday;
    logic [7:0] month_last_day;
    logic       leap;
    logic [7:0] hour_val;
    logic [7:0] hour_next_raw;
    logic       hour_raw_wrap;
    logic [7:0] hour_last;
    logic [7:0] hour_first;
    logic       is12;

    rtc_bcd_digit_pair u_sec (
        .value_in (live.sec),
        .last_in  (SEC_LAST),
        .first_in (BCD_ZERO),
        .next_out (next_sec),
        .wrap_out (sec_wrap)
    );

    rtc_bcd_digit_pair u_min (
        .value_in (live.min),
        .last_in  (MIN_LAST),
        .first_in (BCD_ZERO),
        .next_out (next_min),
        .wrap_out (min_wrap)
    );

    // hour value without format and afternoon bits
    assign is12     = live.hour[FORMAT12_BIT];
    assign hour_val = is12 ? {3'b000, live.hour[4:0]} : {2'b00, live.hour[5:0]};
    assign hour_last  = is12 ? HOUR12_LAST : HOUR24_LAST;
    assign hour_first = is12 ? HOUR12_FIRST : BCD_ZERO;

    rtc_bcd_digit_pair u_hour (
        .value_in (hour_val),
        .last_in  (hour_last),
        .first_in (hour_first),
        .next_out (hour_next_raw),
        .wrap_out (hour_raw_wrap)
    );

    always_comb begin
        if (is12) begin
            // afternoon flag flips on the 11 to 12 step; day ends at 11 pm to 12 am
            next_hour = {1'b0, 1'b1, live.hour[AFTERNOON_BIT] ^ (hour_val == HOUR12_TURN),
                         hour_next_raw[4:0]};
            hour_wrap = live.hour[AFTERNOON_BIT] && (hour_val == HOUR12_TURN);
        end else begin
            next_hour = {2'b00, hour_next_raw[5:0]};
            hour_wrap = hour_raw_wrap;
        end
    end

    // weekday wraps 7 to 1; a zero from reset steps to 1
    assign next_weekday = (live.weekday[2:0] == WEEKDAY_LAST) ? WEEKDAY_FIRST
                        : live.weekday[2:0] + 3'h1;

    // leap years: year divisible by 4, with 00 counted as leap
    assign leap = (live.year[4] == 1'b0) ? (live.year[1:0] == 2'b00)
                                         : (live.year[1:0] == 2'b10);

    always_comb begin
        case ({live.month[MONTH_TEN_BIT], live.month[3:0]})
            5'h02:   month_last_day = leap ? 8'h29 : 8'h28;
            5'h04,
            5'h06,
            5'h09,
            5'h11:   month_last_day = 8'h30;
            default: month_last_day = 8'h31;
        endcase
    end

    rtc_bcd_digit_pair u_mday (
        .value_in ({2'b00, live.mday[5:0]}),
        .last_in  (month_last_day),
        .first_in (BCD_ONE),
        .next_out (next_mday),
        .wrap_out (mday_wrap)
    );

    rtc_bcd_digit_pair u_month (
        .value_in ({3'b000, live.month[4:0]}),
        .last_in  (MONTH_LAST),
        .first_in (BCD_ONE),
        .next_out (next_month),
        .wrap_out (month_wrap)
    );

    rtc_bcd_digit_pair u_year (
        .value_in (live.year),
        .last_in  (YEAR_LAST),
        .first_in (BCD_ZERO),
        .next_out (next_year),
        .wrap_out (year_wrap)
    );

    // seconds
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            seconds <= SEC_RST;
        end else if (sec_write) begin
            seconds <= req_in.wdata & SEC_MASK;
        end else if (tick) begin
            seconds <= next_sec;
        end
    end

    // minutes
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            minutes <= MIN_RST;
        end else if (min_write) begin
            minutes <= req_in.wdata & MIN_MASK;
        end else if (tick && sec_wrap) begin
            minutes <= next_min;
        end
    end

    // hours
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            hours <= HOUR_RST;
        end else if (hour_write) begin
            hours <= req_in.wdata & HOUR_MASK;
        end else if (tick && sec_wrap && min_wrap) begin
            hours <= next_hour;
        end
    end

    // weekday
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            day_of_week <= WEEKDAY_RST;
        end else if (weekday_write) begin
            day_of_week <= req_in.wdata & WEEKDAY_MASK;
        end else if (tick && sec_wrap && min_wrap && hour_wrap) begin
            day_of_week <= {5'b00000, next_weekday};
        end
    end

    // date of month
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            month_day <= MDAY_RST;
        end else if (mday_write) begin
            month_day <= req_in.wdata & MDAY_MASK;
        end else if (tick && sec_wrap && min_wrap && hour_wrap) begin
            month_day <= next_mday;
        end
    end

    // month and century
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            months <= MONTH_RST;
        end else if (month_write) begin
            months <= req_in.wdata & MONTH_MASK;
        end else if (tick && sec_wrap && min_wrap && hour_wrap && mday_wrap) begin
            months[4:0] <= next_month[4:0];
            if (month_wrap && year_wrap) begin
                months[CENTURY_BIT] <= ~months[CENTURY_BIT];
            end
        end
    end

    // year
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            years <= YEAR_RST;
        end else if (year_write) begin
            years <= req_in.wdata & YEAR_MASK;
        end else if (tick && sec_wrap && min_wrap && hour_wrap && mday_wrap
                     && month_wrap) begin
            years <= next_year;
        end
    end

    // shadow copy; a read at pointer zero freezes a consistent snapshot
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            shadow <= '0;
        end else if ((req_in.rd || req_in.wr) && req_in.addr == SNAP_ADDR) begin
            shadow <= live;
        end
    end

    // read port: one cycle after the request
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out  <= 8'h00;
            rvalid_out <= 1'b0;
        end else begin
            rvalid_out <= req_in.rd;
            if (!req_in.rd) begin
                rdata_out <= 8'h00;
            end else if (req_in.addr == SEC_ADDR) begin
                rdata_out <= shadow.sec;
            end else if (req_in.addr == MIN_ADDR) begin
                rdata_out <= shadow.min;
            end else if (req_in.addr == HOUR_ADDR) begin
                rdata_out <= shadow.hour;
            end else if (req_in.addr == WEEKDAY_ADDR) begin
                rdata_out <= shadow.weekday;
            end else if (req_in.addr == MDAY_ADDR) begin
                rdata_out <= shadow.mday;
            end else if (req_in.addr == MONTH_ADDR) begin
                rdata_out <= shadow.month;
            end else if (req_in.addr == YEAR_ADDR) begin
                rdata_out <= shadow.year;
            end else begin
                rdata_out <= 8'h00;
            end
        end
    end

    // tick mirror for observation
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tick_out <= 1'b0;
        end else begin
            tick_out <= tick;
        end
    end

    // half-second window after a seconds write, in which the host finishes setting
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            window_count        <= 32'h0;
            set_window_open_out <= 1'b0;
        end else if (sec_write) begin
            window_count        <= 32'(SET_WINDOW_CYCLES);
            set_window_open_out <= 1'b1;
        end else if (window_count != 32'h0) begin
            window_count        <= window_count - 32'h1;
            set_window_open_out <= (window_count != 32'h1);
        end else begin
            set_window_open_out <= 1'b0;
        end
    end

endmodule

// ==== verification/rtc_timekeeping_counters_sva.sv ====
`timescale 1ns/1ns
module rtc_checker
    import rtc_pkg::*;
#(
    parameter int TICK_CYCLES       = 20,
    parameter int SET_WINDOW_CYCLES = 10
)(
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    // register port
    input  wire reg_req_t   req_in,
    input  wire logic [7:0] rdata_out,
    input  wire logic       rvalid_out,
    // status
    input  wire logic       tick_out,
    input  wire logic       set_window_open_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    logic sec_wr;
    logic wr_d;
    logic steady;
    int   gap;
    int   win;

    assign sec_wr = req_in.wr && req_in.addr == SEC_ADDR;

    // period only judged between two ticks with no restart in between
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            gap    <= 0;
            wr_d   <= 1'b0;
            steady <= 1'b0;
        end else begin
            gap    <= tick_out ? 0 : gap + 1;
            wr_d   <= sec_wr;
            // a tick pulse just after a restart is stale, so skip it too
            steady <= (sec_wr || wr_d) ? 1'b0 : (tick_out ? 1'b1 : steady);
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            win <= 0;
        end else begin
            win <= (sec_wr || !set_window_open_out) ? 0 : win + 1;
        end
    end

    sequence sec_wr_s;
        sec_wr;
    endsequence
    sequence rd_s;
        req_in.rd;
    endsequence

    read_answer_a: assert property (rd_s |=> rvalid_out)
        else $error("read not answered");
    answer_cause_a: assert property (rvalid_out |-> $past(req_in.rd))
        else $error("answer without read");
    idle_data_a: assert property (!rvalid_out |-> rdata_out == 8'h00)
        else $error("data while idle");
    sec_format_a: assert property (rvalid_out && $past(req_in.addr) == SEC_ADDR
        |-> !rdata_out[7] && rdata_out[3:0] <= 4'h9 && rdata_out[6:4] <= 3'h5)
        else $error("seconds not bcd");
    min_format_a: assert property (rvalid_out && $past(req_in.addr) == MIN_ADDR
        |-> !rdata_out[7] && rdata_out[3:0] <= 4'h9 && rdata_out[6:4] <= 3'h5)
        else $error("minutes not bcd");
    unmapped_zero_a: assert property (rvalid_out
        && !($past(req_in.addr) inside {[SEC_ADDR:YEAR_ADDR]}) |-> rdata_out == 8'h00)
        else $error("unmapped read not zero");
    tick_period_a: assert property (tick_out && steady |-> gap == TICK_CYCLES - 1)
        else $error("tick period wrong");
    restart_quiet_a: assert property (sec_wr_s |-> ##3 !tick_out [*8])
        else $error("tick soon after restart");
    window_open_a: assert property (sec_wr_s |=> set_window_open_out [*8])
        else $error("set window not open");
    window_len_a: assert property (win <= SET_WINDOW_CYCLES)
        else $error("set window too long");
endmodule

bind rtc_timekeeping_counters rtc_checker #(
    .TICK_CYCLES      (TICK_CYCLES),
    .SET_WINDOW_CYCLES(SET_WINDOW_CYCLES)
) rtc_checker_i (.clk_in, .rst_in, .req_in, .rdata_out, .rvalid_out, .tick_out,
    .set_window_open_out);

// ==== verification/host_model.sv ====
`timescale 1ns/1ns
// host side of the register port; one request in flight at a time
module host_model
    import rtc_pkg::*;
(
    // clock
    input  wire logic       clk_in,
    // register port
    output reg_req_t        req_out,
    input  wire logic [7:0] rdata_in,
    input  wire logic       rvalid_in
);
    initial req_out = '0;

    // whole-word access, request held for one taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        req_out <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_in);
        req_out <= '0;
    endtask

    // answer stands one cycle, so sample just after the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clk_in);
        req_out <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_in);
        req_out <= '0;
        #1;
        v = rvalid_in;
        d = rdata_in;
    endtask
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/1ns
module tb;
    import rtc_pkg::*;
    localparam int TICKS = 20;
    localparam int WIN   = 10;
    logic       clk_in = 1'b0;
    logic       rst_in = 1'b1;
    reg_req_t   req;
    logic [7:0] rdata;
    logic       rvalid;
    logic       tick;
    logic       win_open;
    int         failures = 0;
    int         compares = 0;
    int         test_no = 0;
    logic [7:0] got;
    logic       vld;
    // start values and the calendar one tick later
    cal_t start_tab [8] = '{56'h59_59_23_07_31_12_99, 56'h59_59_23_03_28_02_23,
        56'h59_59_23_03_28_02_24, 56'h59_59_71_05_30_04_24, 56'h59_59_52_02_15_06_24,
        56'h59_59_51_02_15_06_24, 56'h59_09_10_01_01_01_00, 56'h59_59_23_07_31_92_99};
    cal_t exp_tab [8] = '{56'h00_00_00_01_01_81_00, 56'h00_00_00_04_01_03_23,
        56'h00_00_00_04_29_02_24, 56'h00_00_52_06_01_05_24, 56'h00_00_41_02_15_06_24,
        56'h00_00_72_02_15_06_24, 56'h00_10_10_01_01_01_00, 56'h00_00_00_01_01_01_00};

    always #25 clk_in = ~clk_in;

    rtc_timekeeping_counters #(.TICK_CYCLES(TICKS), .SET_WINDOW_CYCLES(WIN))
    rtc_timekeeping_counters_i (.clk_in, .rst_in, .req_in(req), .rdata_out(rdata),
        .rvalid_out(rvalid), .tick_out(tick), .set_window_open_out(win_open));
    host_model host_model_i (.clk_in, .req_out(req), .rdata_in(rdata), .rvalid_in(rvalid));

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            failures++;
            $display("FAIL at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        host_model_i.rd(a, got, vld);
        chk({7'h00, vld}, 8'h01);
        chk(got, e);
    endtask

    // seconds first so minutes through month land inside the set window
    task automatic load(input cal_t c);
        for (int i = 0; i < 7; i++) begin
            host_model_i.wr(SEC_ADDR + 8'(i), c[55 - 8 * i -: 8]);
        end
    endtask

    task automatic check_all(input cal_t e);
        host_model_i.rd(SNAP_ADDR, got, vld);
        for (int i = 0; i < 7; i++) begin
            rdchk(SEC_ADDR + 8'(i), e[55 - 8 * i -: 8]);
        end
    endtask

    task automatic wait_tick();
        int n;
        n = 0;
        while (tick !== 1'b1 && n < 60) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        chk({7'h00, tick}, 8'h01);
    endtask

    task automatic end_test();
        test_no++;
        $display("test %0d done", test_no);
    endtask

    task automatic tally_and_finish();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        check_all(56'h00_00_00_00_01_01_00);
        end_test();
        load(56'hD9_D9_92_FD_D5_E9_42);
        check_all(56'h59_59_12_05_15_89_42);
        end_test();
        host_model_i.wr(SEC_ADDR, 8'h30);
        #1;
        chk({7'h00, win_open}, 8'h01);
        host_model_i.rd(SNAP_ADDR, got, vld);
        repeat (WIN + 1) @(posedge clk_in);
        #1;
        chk({7'h00, win_open}, 8'h00);
        wait_tick();
        rdchk(SEC_ADDR, 8'h30);
        host_model_i.wr(SNAP_ADDR, 8'h00);
        rdchk(SEC_ADDR, 8'h31);
        wait_tick();
        host_model_i.rd(SNAP_ADDR, got, vld);
        rdchk(SEC_ADDR, 8'h32);
        end_test();
        host_model_i.wr(8'h47, 8'h55);
        rdchk(8'h47, 8'h00);
        rdchk(SNAP_ADDR, 8'h00);
        end_test();
        for (int t = 0; t < 8; t++) begin
            load(start_tab[t]);
            wait_tick();
            check_all(exp_tab[t]);
            end_test();
        end
        tally_and_finish();
    end

    // whole run is under a thousand cycles
    initial begin
        #(3000 * 50);
        failures++;
        tally_and_finish();
    end
endmodule
